// *** design/opdec_top.sv ***
// opdec_top: first-page opcode decoder with memory-clear bus sequencer
`timescale 1ns/1ps
`default_nettype none
// Functional notes
// RULE_01: direct memory ops and clear: 6 cycles, 2 bytes
// RULE_02: 0x60-0x6F indexed memory ops; indexed jump 3
// RULE_03: 0x70-0x7F extended: 7 cycles, 3 bytes; jump 4
// RULE_04: 0x10/0x11 are page prefixes, not instructions
// RULE_05: inherent single-byte opcodes with fixed cycle counts
// RULE_06: long branch 5/3, long call 9/3
// RULE_07: cc or/and 3/2, swap 8/2, copy 6/2
// RULE_08: 0x20-0x2F short branches, 3 cycles 2 bytes
// RULE_09: 0x30-0x33 effective address load, 4+ 2+
// RULE_10: 0x34-0x37 stack push/pull, 5+ cycles 2 bytes
// RULE_11: interrupt return 6/15; masked wait 20/2
// RULE_12: accumulator A and B rows, 2 cycles 1 byte
// RULE_13: 0x80-0x8B immediate A ops; wide subtract 4/3
// RULE_14: index compare 4/3, call 7/2, index load 3/3
// RULE_15: unused opcodes are flagged illegal
// RULE_16: clear reads the target, then writes zero
// RULE_17: extended clear runs seven bus steps with idles
// RULE_18: indexed extras from postbyte added to base
// RULE_19: illegal flag and registered outputs one clock later
// RULE_20: reset drops pending prefix page state
module opdec_top (
	input  wire logic                 clock,       // 50 MHz processor clock
	input  wire logic                 rst_n,       // asynchronous reset, active low
	input  wire logic                 op_valid,    // opcode byte valid this cycle
	input  wire logic [7:0]           op_byte,     // opcode byte from fetch
	input  wire logic                 pb_valid,    // postbyte extras valid
	input  wire logic [3:0]           pb_cycles,   // extra cycles from postbyte
	input  wire logic [1:0]           pb_bytes,    // extra bytes from postbyte
	input  wire logic [15:0]          pc,          // address of the opcode
	input  wire logic [15:0]          ea,          // effective target address
	output opdec_pkg::opdec_info_t    info_r,      // decoded fields
	output logic                      info_vld_r,  // info_r refreshed, one cycle
	output logic [5:0]                tot_cyc_r,   // base plus indexed extra cycles
	output logic [2:0]                tot_len_r,   // base plus indexed extra bytes
	output logic                      tot_vld_r,   // totals refreshed, one cycle
	output opdec_pkg::opdec_bus_t     bus_r,       // clear sequence bus step
	output logic                      clr_busy_r   // clear sequence running
);
	// ****************************************
	// decode table
	// ****************************************
	function automatic opdec_pkg::opdec_info_t decode(input logic [7:0] b);
		opdec_pkg::opdec_info_t d;
		logic [3:0] lo;
		lo = b[3:0];
		d = '{op_class: opdec_pkg::CL_ILLEGAL, sub_op: lo, mode: opdec_pkg::MD_NONE,
			cycles: 5'h00, length: 2'h0, variable: 1'b0, illegal: 1'b1, page: opdec_pkg::PG_FIRST};
		unique case (b[7:4])
			4'h0, 4'h6, 4'h7: begin
				// RULE_01 direct memory row
				if (opdec_pkg::MEM_LEGAL[lo]) begin
					d.illegal = 1'b0;
					d.op_class = (lo == opdec_pkg::NIB_JUMP) ? opdec_pkg::CL_JUMP : opdec_pkg::CL_RMW;
					d.mode = opdec_pkg::MD_DIRECT;
					d.length = 2'h2;
					d.cycles = (lo == opdec_pkg::NIB_JUMP) ? opdec_pkg::CYC_JMP : opdec_pkg::CYC_MEM;
					// RULE_02 indexed row, base counts
					if (b[7:4] == 4'h6) begin
						d.mode = opdec_pkg::MD_INDEXED;
						d.variable = 1'b1;
					end
					// RULE_03 extended row
					if (b[7:4] == 4'h7) begin
						d.mode = opdec_pkg::MD_EXTENDED;
						d.length = 2'h3;
						d.cycles = (lo == opdec_pkg::NIB_JUMP) ? opdec_pkg::CYC_JMP_X : opdec_pkg::CYC_MEM_X;
					end
				end
			end
			4'h1: begin
				d.illegal = 1'b0;
				d.length = 2'h1;
				d.mode = opdec_pkg::MD_INHERENT;
				d.op_class = opdec_pkg::CL_INHERENT;
				unique case (lo)
					// RULE_04 page prefixes carry no instruction
					4'h0, 4'h1: begin
						d.op_class = opdec_pkg::CL_PREFIX;
						d.mode = opdec_pkg::MD_NONE;
						d.length = 2'h0;
					end
					// RULE_05 inherent counts
					4'h2, 4'h3, 4'h9, 4'hD: d.cycles = opdec_pkg::CYC_ACC;
					// RULE_06 long branch and long call
					4'h6, 4'h7: begin
						d.op_class = (lo[0]) ? opdec_pkg::CL_LCALL : opdec_pkg::CL_LBRANCH;
						d.mode = opdec_pkg::MD_RELATIVE;
						d.cycles = (lo[0]) ? opdec_pkg::CYC_LCALL : opdec_pkg::CYC_LONG_BRANCH_ALWAYS;
						d.length = 2'h3;
					end
					// RULE_07 condition-code ops and register moves
					4'hA, 4'hC: begin
						d.op_class = opdec_pkg::CL_CCOP;
						d.mode = opdec_pkg::MD_IMMED;
						d.cycles = opdec_pkg::CYC_CCOP;
						d.length = 2'h2;
					end
					4'hE, 4'hF: begin
						d.op_class = opdec_pkg::CL_REGMOVE;
						d.cycles = (lo[0]) ? opdec_pkg::CYC_COPY : opdec_pkg::CYC_SWAP;
						d.length = 2'h2;
					end
					// RULE_15 unused in this row
					default: d = decode_bad(lo);
				endcase
			end
			4'h2: begin
				// RULE_08 short branches, condition in low nibble
				d.illegal = 1'b0;
				d.op_class = opdec_pkg::CL_BRANCH;
				d.mode = opdec_pkg::MD_RELATIVE;
				d.cycles = opdec_pkg::CYC_BRA;
				d.length = 2'h2;
			end
			4'h3: begin
				d.illegal = 1'b0;
				d.length = 2'h1;
				d.mode = opdec_pkg::MD_INHERENT;
				d.op_class = opdec_pkg::CL_INHERENT;
				unique case (lo)
					// RULE_09 effective address load, X Y S U
					4'h0, 4'h1, 4'h2, 4'h3: begin
						d.op_class = opdec_pkg::CL_LEA;
						d.mode = opdec_pkg::MD_INDEXED;
						d.cycles = opdec_pkg::CYC_LEA;
						d.length = 2'h2;
						d.variable = 1'b1;
					end
					// RULE_10 push and pull, plus one per byte
					4'h4, 4'h5, 4'h6, 4'h7: begin
						d.op_class = opdec_pkg::CL_STACK;
						d.cycles = opdec_pkg::CYC_STACK;
						d.length = 2'h2;
						d.variable = 1'b1;
					end
					// RULE_05 return, index add, multiply, trap
					4'h9: d.cycles = opdec_pkg::CYC_RET;
					4'hA: d.cycles = opdec_pkg::CYC_IXADD;
					4'hD: d.cycles = opdec_pkg::CYC_MUL;
					4'hF: d.cycles = opdec_pkg::CYC_TRAP;
					// RULE_11 short return is the base; full return 15
					4'hB: begin
						d.cycles = opdec_pkg::CYC_RTI;
						d.variable = 1'b1;
					end
					4'hC: begin
						d.cycles = opdec_pkg::CYC_WAIT;
						d.length = 2'h2;
					end
					default: d = decode_bad(lo);
				endcase
			end
			4'h4, 4'h5: begin
				// RULE_12 accumulator rows
				if (opdec_pkg::ACC_LEGAL[lo]) begin
					d.illegal = 1'b0;
					d.op_class = opdec_pkg::CL_RMW;
					d.mode = opdec_pkg::MD_INHERENT;
					d.cycles = opdec_pkg::CYC_ACC;
					d.length = 2'h1;
				end
			end
			4'h8: begin
				d.illegal = 1'b0;
				d.mode = opdec_pkg::MD_IMMED;
				d.op_class = opdec_pkg::CL_ALU;
				d.cycles = opdec_pkg::CYC_ACC;
				d.length = 2'h2;
				unique case (lo)
					// RULE_13 wide subtract; RULE_14 index compare
					4'h3, 4'hC: begin
						d.cycles = opdec_pkg::CYC_WIDE;
						d.length = 2'h3;
					end
					// RULE_14 short call and index load
					4'hD: begin
						d.op_class = opdec_pkg::CL_CALL;
						d.mode = opdec_pkg::MD_RELATIVE;
						d.cycles = opdec_pkg::CYC_CALL;
					end
					4'hE: begin
						d.cycles = opdec_pkg::CYC_IXLD;
						d.length = 2'h3;
					end
					// RULE_15 unused immediate slots
					4'h7, 4'hF: d = decode_bad(lo);
					default: d.cycles = opdec_pkg::CYC_ACC;
				endcase
			end
			default: begin
				// 0x90-0xFF handled by a separate table
				d.illegal = 1'b0;
				d.op_class = opdec_pkg::CL_OUTSIDE;
			end
		endcase
		return d;
	endfunction

	function automatic opdec_pkg::opdec_info_t decode_bad(input logic [3:0] lo);
		return '{op_class: opdec_pkg::CL_ILLEGAL, sub_op: lo, mode: opdec_pkg::MD_NONE,
			cycles: 5'h00, length: 2'h0, variable: 1'b0, illegal: 1'b1, page: opdec_pkg::PG_FIRST};
	endfunction

	// ****************************************
	// prefix page and decode register
	// ****************************************
	opdec_pkg::opdec_page_t page_r;
	opdec_pkg::opdec_info_t info_nxt;
	logic                   is_prefix;

	assign is_prefix = (op_byte == opdec_pkg::PFX_PAGE2) || (op_byte == opdec_pkg::PFX_PAGE3);

	always_comb begin
		info_nxt = decode(op_byte);
		// a paged byte belongs to the second- or third-page table, not this one
		if (page_r != opdec_pkg::PG_FIRST) begin
			info_nxt = '{op_class: opdec_pkg::CL_PAGED, sub_op: op_byte[3:0], mode: opdec_pkg::MD_NONE,
				cycles: 5'h00, length: 2'h0, variable: 1'b0, illegal: 1'b0, page: page_r};
		end
	end

	// RULE_20 reset and paged byte both end prefix state
	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			page_r <= opdec_pkg::PG_FIRST;
		end else if (op_valid) begin
			if (page_r == opdec_pkg::PG_FIRST && is_prefix)
				page_r <= op_byte[0] ? opdec_pkg::PG_THIRD : opdec_pkg::PG_SECOND;
			else
				page_r <= opdec_pkg::PG_FIRST;
		end
	end

	// RULE_19 fields registered one clock after the byte
	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			info_r <= '0;
			info_vld_r <= 1'b0;
		end else begin
			info_vld_r <= op_valid;
			if (op_valid)
				info_r <= info_nxt;
		end
	end

	// RULE_18 postbyte extras added to the indexed base
	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			tot_cyc_r <= '0;
			tot_len_r <= '0;
			tot_vld_r <= 1'b0;
		end else begin
			tot_vld_r <= 1'b0;
			if (info_vld_r) begin
				tot_cyc_r <= {1'b0, info_r.cycles};
				tot_len_r <= {1'b0, info_r.length};
				tot_vld_r <= (info_r.mode != opdec_pkg::MD_INDEXED);
			end else if (pb_valid && info_r.mode == opdec_pkg::MD_INDEXED) begin
				tot_cyc_r <= {1'b0, info_r.cycles} + {2'b00, pb_cycles};
				tot_len_r <= {1'b0, info_r.length} + {1'b0, pb_bytes};
				tot_vld_r <= 1'b1;
			end
		end
	end

	// ****************************************
	// memory clear bus sequence
	// ****************************************
	typedef enum logic [2:0] {ST_IDLE, ST_FETCH, ST_OPR_HI, ST_OPR_LO, ST_GAP1, ST_READ,
		ST_GAP2, ST_WRITE} opdec_clr_t;
	opdec_clr_t             clr_r;
	opdec_pkg::opdec_mode_t clr_mode_r;
	logic                   clr_go;

	assign clr_go = info_vld_r && info_r.op_class == opdec_pkg::CL_RMW
		&& info_r.sub_op == opdec_pkg::NIB_CLEAR && info_r.mode != opdec_pkg::MD_INHERENT;

	// RULE_16 read target before writing zero; RULE_17 idles at top address
	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			clr_r <= ST_IDLE;
			clr_mode_r <= opdec_pkg::MD_NONE;
		end else begin
			unique case (clr_r)
				ST_IDLE: if (clr_go) begin
					clr_r <= ST_FETCH;
					clr_mode_r <= info_r.mode;
				end
				ST_FETCH: clr_r <= ST_OPR_HI;
				ST_OPR_HI: clr_r <= (clr_mode_r == opdec_pkg::MD_EXTENDED) ? ST_OPR_LO : ST_GAP1;
				ST_OPR_LO: clr_r <= ST_GAP1;
				ST_GAP1: clr_r <= ST_READ;
				ST_READ: clr_r <= ST_GAP2;
				ST_GAP2: clr_r <= ST_WRITE;
				ST_WRITE: clr_r <= ST_IDLE;
			endcase
		end
	end

	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			bus_r <= '{addr: opdec_pkg::IDLE_ADDR, wdata: opdec_pkg::ZERO_BYTE, rw: 1'b1, active: 1'b0};
		end else begin
			bus_r.active <= (clr_r != ST_IDLE);
			bus_r.rw <= (clr_r != ST_WRITE);
			bus_r.wdata <= opdec_pkg::ZERO_BYTE;
			unique case (clr_r)
				ST_FETCH: bus_r.addr <= pc;
				ST_OPR_HI: bus_r.addr <= pc + 16'h0001;
				ST_OPR_LO: bus_r.addr <= pc + 16'h0002;
				ST_READ, ST_WRITE: bus_r.addr <= ea;
				default: bus_r.addr <= opdec_pkg::IDLE_ADDR;
			endcase
		end
	end

	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n)
			clr_busy_r <= 1'b0;
		else
			clr_busy_r <= (clr_r != ST_IDLE);
	end

	// ****************************************
	// assertions
	// ****************************************
	sequence clr_read_s;
		bus_r.active && bus_r.rw && bus_r.addr == $past(ea);
	endsequence
	sequence clr_gap_s;
		bus_r.active && bus_r.addr == opdec_pkg::IDLE_ADDR;
	endsequence
	sequence clr_write_s;
		bus_r.active && !bus_r.rw && bus_r.wdata == opdec_pkg::ZERO_BYTE;
	endsequence

	prefix_no_instr_a: assert property (@(posedge clock) disable iff (!rst_n) // RULE_04
		op_valid && is_prefix && page_r == opdec_pkg::PG_FIRST |=> info_r.length == 2'h0
		&& page_r != opdec_pkg::PG_FIRST) else $error("prefix decoded as instruction");
	direct_clear_a: assert property (@(posedge clock) disable iff (!rst_n) // RULE_01
		op_valid && op_byte == 8'h0F && page_r == opdec_pkg::PG_FIRST |=> info_r.cycles == 5'h06
		&& info_r.length == 2'h2) else $error("direct clear counts wrong");
	ext_jump_a: assert property (@(posedge clock) disable iff (!rst_n) // RULE_03
		op_valid && op_byte == 8'h7E && page_r == opdec_pkg::PG_FIRST |=> info_r.cycles == 5'h04
		&& info_r.length == 2'h3) else $error("extended jump counts wrong");
	unused_illegal_a: assert property (@(posedge clock) disable iff (!rst_n) // RULE_15
		op_valid && page_r == opdec_pkg::PG_FIRST && (op_byte == 8'h87 || op_byte == 8'h01
		|| op_byte == 8'h38) |=> info_r.illegal) else $error("unused opcode not illegal");
	branch_counts_a: assert property (@(posedge clock) disable iff (!rst_n) // RULE_08
		op_valid && page_r == opdec_pkg::PG_FIRST && op_byte[7:4] == 4'h2 |=> info_r.cycles == 5'h03
		&& info_r.op_class == opdec_pkg::CL_BRANCH) else $error("short branch counts wrong");
	one_clock_a: assert property (@(posedge clock) disable iff (!rst_n) // RULE_19
		op_valid |=> info_vld_r && info_r == $past(info_nxt)) else $error("decode not registered");
	page_clear_a: assert property (@(posedge clock) disable iff (!rst_n) // RULE_20
		op_valid && page_r != opdec_pkg::PG_FIRST |=> page_r == opdec_pkg::PG_FIRST
		&& info_r.op_class == opdec_pkg::CL_PAGED) else $error("prefix state not dropped");
	idx_extra_a: assert property (@(posedge clock) disable iff (!rst_n) // RULE_18
		pb_valid && !info_vld_r && info_r.mode == opdec_pkg::MD_INDEXED |=> tot_vld_r
		&& tot_cyc_r == $past({1'b0, info_r.cycles}) + $past({2'b00, pb_cycles}))
		else $error("indexed extras not added");
	ext_clear_seq_a: assert property (@(posedge clock) disable iff (!rst_n) // RULE_17
		clr_go && info_r.mode == opdec_pkg::MD_EXTENDED && clr_r == ST_IDLE
		|=> ##4 clr_gap_s ##1 clr_read_s ##1 clr_gap_s ##1 clr_write_s)
		else $error("extended clear steps wrong");
	read_first_a: assert property (@(posedge clock) disable iff (!rst_n) // RULE_16
		clr_write_s |-> $past(bus_r.rw, 2) && $past(bus_r.active, 2)
		&& $past(bus_r.addr, 2) == bus_r.addr) else $error("clear wrote without read");
endmodule
`default_nettype wire

// *** include/opdec_pkg.sv ***
// opdec_pkg: shared types and constants of the first-page opcode decoder
`default_nettype none
package opdec_pkg;
	// ****************************************
	// encodings and addresses
	// ****************************************
	localparam logic [7:0]  PFX_PAGE2  = 8'h10;
	localparam logic [7:0]  PFX_PAGE3  = 8'h11;
	localparam logic [15:0] IDLE_ADDR  = 16'hFFFF;
	localparam logic [7:0]  ZERO_BYTE  = 8'h00;
	localparam logic [3:0]  NIB_JUMP   = 4'hE;
	localparam logic [3:0]  NIB_CLEAR  = 4'hF;
	// legal low nibbles of the memory and accumulator rows, bit n = nibble n
	localparam logic [15:0] MEM_LEGAL  = 16'hF7D9;
	localparam logic [15:0] ACC_LEGAL  = 16'hB7D9;
	// ****************************************
	// base cycle counts
	// ****************************************
	localparam logic [4:0] CYC_ACC    = 5'h02;
	localparam logic [4:0] CYC_MEM    = 5'h06;
	localparam logic [4:0] CYC_MEM_X  = 5'h07;
	localparam logic [4:0] CYC_JMP    = 5'h03;
	localparam logic [4:0] CYC_JMP_X  = 5'h04;
	localparam logic [4:0] CYC_BRA    = 5'h03;
	localparam logic [4:0] CYC_LONG_BRANCH_ALWAYS   = 5'h05;
	localparam logic [4:0] CYC_LCALL  = 5'h09;
	localparam logic [4:0] CYC_CCOP   = 5'h03;
	localparam logic [4:0] CYC_SWAP   = 5'h08;
	localparam logic [4:0] CYC_COPY   = 5'h06;
	localparam logic [4:0] CYC_LEA    = 5'h04;
	localparam logic [4:0] CYC_STACK  = 5'h05;
	localparam logic [4:0] CYC_RET    = 5'h05;
	localparam logic [4:0] CYC_IXADD  = 5'h03;
	localparam logic [4:0] CYC_RTI    = 5'h06;
	localparam logic [4:0] CYC_RTI_F  = 5'h0F;
	localparam logic [4:0] CYC_WAIT   = 5'h14;
	localparam logic [4:0] CYC_MUL    = 5'h0B;
	localparam logic [4:0] CYC_TRAP   = 5'h13;
	localparam logic [4:0] CYC_WIDE   = 5'h04;
	localparam logic [4:0] CYC_CALL   = 5'h07;
	localparam logic [4:0] CYC_IXLD   = 5'h03;
	// ****************************************
	// types
	// ****************************************
	typedef enum logic [1:0] {PG_FIRST, PG_SECOND, PG_THIRD} opdec_page_t;
	typedef enum logic [2:0] {MD_NONE, MD_INHERENT, MD_IMMED, MD_DIRECT,
		MD_INDEXED, MD_EXTENDED, MD_RELATIVE} opdec_mode_t;
	typedef enum logic [3:0] {CL_ILLEGAL, CL_PREFIX, CL_PAGED, CL_OUTSIDE, CL_RMW, CL_JUMP,
		CL_BRANCH, CL_LBRANCH, CL_LCALL, CL_CALL, CL_INHERENT, CL_CCOP, CL_REGMOVE,
		CL_LEA, CL_STACK, CL_ALU} opdec_class_t;
	typedef struct packed {
		opdec_class_t op_class;  // operation class
		logic [3:0]   sub_op;    // operation within the class (low nibble)
		opdec_mode_t  mode;      // addressing mode
		logic [4:0]   cycles;    // base cycle count
		logic [1:0]   length;    // base byte count, zero for prefix
		logic         variable;  // count grows with postbyte, mask or state
		logic         illegal;   // unused encoding
		opdec_page_t  page;      // page the byte was decoded on
	} opdec_info_t;
	typedef struct packed {
		logic [15:0] addr;   // bus address
		logic [7:0]  wdata;  // write data
		logic        rw;     // 1 read, 0 write
		logic        active; // step is valid
	} opdec_bus_t;
endpackage
`default_nettype wire

// *** sim/opdec_fetch_model.sv ***
// fetch unit model: feeds opcode bytes and postbyte extras to the decoder
`timescale 1ns/1ps
`default_nettype none
module opdec_fetch_model (
	input  wire logic       clock,      // processor clock
	output logic            op_valid,   // opcode strobe
	output logic [7:0]      op_byte,    // opcode byte
	output logic            pb_valid,   // postbyte extras strobe
	output logic [3:0]      pb_cycles,  // extra cycles
	output logic [1:0]      pb_bytes    // extra bytes
);
	initial begin
		op_valid = 1'b0;
		op_byte = 8'h5A;
		pb_valid = 1'b0;
		pb_cycles = 4'hA;
		pb_bytes = 2'h1;
	end
	task automatic put(input logic [7:0] b);
		@(negedge clock);
		op_valid = 1'b1;
		op_byte = b;
		pb_valid = 1'b0;
	endtask
	// released lines flip so a stale byte never passes for a fresh one
	task automatic idle();
		@(negedge clock);
		op_valid = 1'b0;
		op_byte = ~op_byte;
		pb_valid = 1'b0;
		pb_cycles = ~pb_cycles;
		pb_bytes = ~pb_bytes;
	endtask
	task automatic post(input logic [3:0] c, input logic [1:0] n);
		@(negedge clock);
		op_valid = 1'b0;
		op_byte = ~op_byte;
		pb_valid = 1'b1;
		pb_cycles = c;
		pb_bytes = n;
	endtask
endmodule
`default_nettype wire

// *** sim/opdec_top_bench.sv ***
// self-checking bench of the first-page opcode decoder
`timescale 1ns/1ps
`default_nettype none
`define CHK(g, e, m) begin tests_run++; if ((g) !== (e)) begin n_errors++; $display("wrong value at %0t: %s", $time, m); end end
module opdec_top_bench;
	logic                    clock;       // bench clock
	logic                    rst_n;       // reset, active low
	logic                    op_valid;    // from fetch model
	logic [7:0]              op_byte;     // from fetch model
	logic                    pb_valid;    // from fetch model
	logic [3:0]              pb_cycles;   // from fetch model
	logic [1:0]              pb_bytes;    // from fetch model
	logic [15:0]             pc;          // opcode address
	logic [15:0]             ea;          // target address
	opdec_pkg::opdec_info_t  info_r;      // decoded fields
	logic                    info_vld_r;  // decode pulse
	logic [5:0]              tot_cyc_r;   // total cycles
	logic [2:0]              tot_len_r;   // total bytes
	logic                    tot_vld_r;   // totals pulse
	opdec_pkg::opdec_bus_t   bus_r;       // clear bus step
	logic                    clr_busy_r;  // clear running
	int                      n_errors;
	int                      tests_run;
	logic [15:0]             expq[$];
	logic [31:0]             seed;
	// ****************************************
	// reference decode {illegal, length, cycles}
	// ****************************************
	localparam logic [7:0] T1 [16] = '{8'hFF, 8'hFF, 8'h22, 8'h22, 8'h80, 8'h80, 8'h65, 8'h69,
		8'h80, 8'h22, 8'h43, 8'h80, 8'h43, 8'h22, 8'h48, 8'h46};
	localparam logic [7:0] T3 [16] = '{8'h44, 8'h44, 8'h44, 8'h44, 8'h45, 8'h45, 8'h45, 8'h45,
		8'h80, 8'h25, 8'h23, 8'h26, 8'h54, 8'h2B, 8'h80, 8'h33};
	localparam logic [7:0] T8 [16] = '{8'h42, 8'h42, 8'h42, 8'h64, 8'h42, 8'h42, 8'h42, 8'h80,
		8'h42, 8'h42, 8'h42, 8'h42, 8'h64, 8'h47, 8'h63, 8'h80};
	function automatic logic [7:0] ref_dec(input logic [7:0] b);
		logic un;
		un = (b[3:0] == 4'h1) || (b[3:0] == 4'h2) || (b[3:0] == 4'h5) || (b[3:0] == 4'hB);
		case (b[7:4])
			4'h0, 4'h6: return un ? 8'h80 : ((b[3:0] == 4'hE) ? 8'h43 : 8'h46);
			4'h7: return un ? 8'h80 : ((b[3:0] == 4'hE) ? 8'h64 : 8'h67);
			4'h4, 4'h5: return (un || b[3:0] == 4'hE) ? 8'h80 : 8'h22;
			4'h1: return T1[b[3:0]];
			4'h2: return 8'h43;
			4'h3: return T3[b[3:0]];
			4'h8: return T8[b[3:0]];
			default: return 8'hFC;
		endcase
	endfunction
	function automatic logic [31:0] rnd();
		seed ^= seed << 13;
		seed ^= seed >> 17;
		seed ^= seed << 5;
		return seed;
	endfunction
	opdec_fetch_model fetch (.clock(clock), .op_valid(op_valid), .op_byte(op_byte), .pb_valid(pb_valid),
		.pb_cycles(pb_cycles), .pb_bytes(pb_bytes));
	opdec_top dut (.clock(clock), .rst_n(rst_n), .op_valid(op_valid), .op_byte(op_byte), .pb_valid(pb_valid),
		.pb_cycles(pb_cycles), .pb_bytes(pb_bytes), .pc(pc), .ea(ea), .info_r(info_r),
		.info_vld_r(info_vld_r), .tot_cyc_r(tot_cyc_r), .tot_len_r(tot_len_r), .tot_vld_r(tot_vld_r),
		.bus_r(bus_r), .clr_busy_r(clr_busy_r));
	initial begin
		clock = 1'b0;
		forever #10 clock = ~clock;
	end
	// ****************************************
	// monitor: oldest note against each decode pulse
	// ****************************************
	always @(negedge clock) begin
		logic [15:0] e;
		if (info_vld_r === 1'b1) begin
			if (expq.size() == 0) begin
				`CHK(1'b1, 1'b0, "decode pulse without request")
			end else begin
				e = expq.pop_front();
				`CHK(info_r.sub_op, e[11:8], "sub operation")
				case (e[7:0])
					8'hFF: `CHK({info_r.op_class, info_r.length}, {opdec_pkg::CL_PREFIX, 2'h0}, "prefix")
					8'hFE: `CHK({info_r.op_class, info_r.page}, {opdec_pkg::CL_PAGED, opdec_pkg::PG_SECOND}, "page")
					8'hFD: `CHK({info_r.op_class, info_r.page}, {opdec_pkg::CL_PAGED, opdec_pkg::PG_THIRD}, "page")
					8'hFC: `CHK({info_r.op_class, info_r.illegal}, {opdec_pkg::CL_OUTSIDE, 1'b0}, "outside")
					8'h80: `CHK(info_r.illegal, 1'b1, "unused not illegal")
					default: `CHK({info_r.illegal, info_r.length, info_r.cycles}, e[7:0], "counts")
				endcase
			end
		end
	end
	task automatic send(input logic [7:0] b, input logic [7:0] e);
		fetch.put(b);
		expq.push_back({b, e});
	endtask
	task automatic tot_check(input logic [7:0] b, input logic idx, input opdec_pkg::opdec_mode_t m);
		logic [3:0] c;
		logic [1:0] n;
		logic [5:0] ec;
		logic [2:0] el;
		int i;
		c = idx ? 4'(rnd()) : 4'h0;
		n = idx ? 2'(rnd()) : 2'h0;
		ec = 6'(ref_dec(b) & 8'h1F) + {2'h0, c};
		el = 3'(ref_dec(b) >> 5) + {1'b0, n};
		send(b, ref_dec(b));
		fetch.idle();
		if (idx) begin
			fetch.post(c, n);
			fetch.idle();
		end
		for (i = 0; i < 6 && tot_vld_r !== 1'b1; i++) @(negedge clock);
		`CHK({tot_vld_r, tot_cyc_r, tot_len_r}, {1'b1, ec, el}, "totals")
		`CHK({info_r.mode, info_r.variable}, {m, idx}, "mode")
	endtask
	task automatic clr_check(input logic [7:0] b, input int n);
		int i;
		logic [15:0] ad;
		pc = 16'(rnd());
		ea = 16'(rnd());
		send(b, ref_dec(b));
		fetch.idle();
		for (i = 0; i < 8 && bus_r.active !== 1'b1; i++) @(negedge clock);
		for (i = 0; i < n; i++) begin
			ad = (i == n - 1 || i == n - 3) ? ea : ((i == n - 2 || i == n - 4) ? 16'hFFFF : pc + 16'(i));
			`CHK({bus_r.active, clr_busy_r, bus_r.addr, bus_r.rw}, {2'b11, ad, i != n - 1}, "clear step")
			if (i == n - 1) `CHK(bus_r.wdata, 8'h00, "clear data")
			@(negedge clock);
		end
		`CHK({bus_r.active, clr_busy_r}, 2'b00, "clear end")
	endtask
	task automatic test_done();
		`CHK(expq.size(), 0, "missing decode pulses")
		$display("comparisons %0d mismatches %0d", tests_run, n_errors);
		if (n_errors == 0 && tests_run > 0) begin
			$display("Simulation passed");
		end else begin
			$display("Simulation failed");
		end
		$finish;
	endtask
	initial begin
		#200us;
		`CHK(1'b1, 1'b0, "run timeout")
		test_done();
	end
	initial begin
		int i;
		seed = 32'h3AF7;
		n_errors = 0;
		tests_run = 0;
		rst_n = 1'b0;
		pc = 16'h8000;
		ea = 16'hA000;
		repeat (4) @(negedge clock);
		rst_n = 1'b1;
		// opcode map sweep, random gaps, prefixes kept apart
		for (i = 0; i < 8'h90; i++) begin
			if (i != 8'h10 && i != 8'h11) send(8'(i), ref_dec(8'(i)));
			if (rnd() & 32'h1) fetch.idle();
		end
		for (i = 0; i < 16; i++) send(8'h90 + 8'(rnd() % 112), 8'hFC);
		fetch.idle();
		repeat (12) @(negedge clock);
		$display("done: opcode sweep");
		send(8'h10, 8'hFF);
		send(8'h3F, 8'hFE);
		send(8'h11, 8'hFF);
		send(8'h11, 8'hFD);
		send(8'h12, 8'h22);
		send(8'h10, 8'hFF);
		fetch.idle();
		@(negedge clock);
		rst_n = 1'b0;
		@(negedge clock);
		`CHK({info_vld_r, tot_vld_r, bus_r.active, clr_busy_r}, 4'h0, "reset outputs")
		rst_n = 1'b1;
		send(8'h3F, 8'h33);
		fetch.idle();
		$display("done: prefix pages and reset");
		tot_check(8'h16, 1'b0, opdec_pkg::MD_RELATIVE);
		tot_check(8'h8E, 1'b0, opdec_pkg::MD_IMMED);
		// low nibbles 0, 4, 8, C only: all legal and none is the clear
		for (i = 0; i < 4; i++) tot_check(8'h60 | (8'(rnd()) & 8'h0C), 1'b1, opdec_pkg::MD_INDEXED);
		$display("done: totals");
		clr_check(8'h7F, 7);
		clr_check(8'h0F, 6);
		clr_check(8'h6F, 6);
		send(8'h4F, 8'h22);
		fetch.idle();
		for (i = 0; i < 6 && bus_r.active !== 1'b1; i++) @(negedge clock);
		`CHK(bus_r.active, 1'b0, "accumulator clear on bus")
		$display("done: clear sequences");
		repeat (4) @(negedge clock);
		test_done();
	end
endmodule
`default_nettype wire
